// File: include/sar_readout_pkg.sv
// shared constants and carrier types for the serial result readout
package sar_readout_pkg;
  localparam int RESULT_W = 16;
  localparam int CNT_W = 6;
  // falling shift clock edges that close the sampling interval
  localparam logic [CNT_W-1:0] SAMPLE_EDGES = 6'h05;
  // edges at which the null bit, first result bit and reversed run begin
  localparam logic [CNT_W-1:0] NULL_EDGE = 6'h05;
  localparam logic [CNT_W-1:0] MSB_EDGE = 6'h06;
  localparam logic [CNT_W-1:0] REV_EDGE = 6'h16;
  localparam logic [CNT_W-1:0] DONE_EDGE = 6'h26;
  localparam int SYNC_STAGES = 3;
  localparam int CLK_PERIOD_PS = 4000;
  // shortest shift clock period served at 100 kHz conversion rate
  localparam int BIT_TIME_NS = 416;
  localparam int BIT_CYCLES = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

  typedef enum logic [1:0] {IDLE, SAMPLE, SHIFT, DONE} phase_t;

  typedef struct packed {
    logic o;
    logic oe;
  } dout_pin_t;

  typedef struct packed {
    logic analog_pd;
    logic digital_pd;
  } power_t;
endpackage

// File: core/sar_serial_readout.sv
// serial readout and cycle control of a 16-bit sampling converter
// Functional notes
// - output bit changes on each falling shift clock edge.
// - falling select starts conversion and transfer.
// - first 4.5 to 5 clock periods sample the input.
// - after fifth falling edge, output enabled driving one LOW null bit.
// - next 16 periods send result, most significant bit first.
// - after bottom bit, result repeats starting from the bottom bit.
// - after top bit resent, output high impedance; further clocks ignored.
// - new conversion needs select high then low; clocks ignored meanwhile.
// - result is unsigned straight binary.
// - power down after conversion completes and whenever select is high.
// - select low after completion powers down analog only.
// - digital logic fully shuts down only while select is high.
// - each bit presented when decided; raising select aborts anytime.
// - one bit decided per shift clock, down to 416 ns periods.
// - output high impedance for whole sampling interval.
`timescale 1ns/100ps
module sar_serial_readout
  import sar_readout_pkg::*;
#(
  parameter int WIDTH = RESULT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // converter side: analog comparator, decides the bit being tried
  input wire logic comparator,
  // serial link pins
  input wire logic serial_shift_clock,
  input wire logic select_n,
  output sar_readout_pkg::dout_pin_t dout,
  // status
  output sar_readout_pkg::power_t power,
  output logic [WIDTH-1:0] result,
  output logic result_valid
);
  import sar_readout_pkg::*;

  if (WIDTH != RESULT_W) begin : g_width_check
    $error("only a 16-bit result is supported");
  end

  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic srst_n = rst_sync_q;

  // three stages; a change counts once stages two and three agree
  logic [SYNC_STAGES-1:0] sclk_q, sclk_d, sel_q, sel_d;
  logic sclk_st_q, sclk_st_d, sel_st_q, sel_st_d;
  wire logic sclk_s = (sclk_q[1] == sclk_q[2]) ? sclk_q[2] : sclk_st_q;
  wire logic sel_s = (sel_q[1] == sel_q[2]) ? sel_q[2] : sel_st_q;
  wire logic sclk_fall = sclk_st_q & ~sclk_s;
  wire logic sel_fall = sel_st_q & ~sel_s;

  always_comb begin
    sclk_d = {sclk_q[SYNC_STAGES-2:0], serial_shift_clock};
    sel_d = {sel_q[SYNC_STAGES-2:0], select_n};
    sclk_st_d = sclk_s;
    sel_st_d = sel_s;
  end

  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      sclk_q <= '0;
      sel_q <= '1;
      sclk_st_q <= 1'b0;
      sel_st_q <= 1'b1;
    end else begin
      sclk_q <= sclk_d;
      sel_q <= sel_d;
      sclk_st_q <= sclk_st_d;
      sel_st_q <= sel_st_d;
    end
  end

  phase_t phase_q, phase_d;
  logic [CNT_W-1:0] edge_q, edge_d;
  logic [WIDTH-1:0] sar_q, sar_d;
  logic [WIDTH-1:0] res_q, res_d;
  logic valid_q, valid_d;
  dout_pin_t dout_q, dout_d;
  power_t pwr_q, pwr_d;
  logic [CNT_W-1:0] idx;

  always_comb begin
    phase_d = phase_q;
    edge_d = edge_q;
    sar_d = sar_q;
    res_d = res_q;
    valid_d = valid_q;
    dout_d = dout_q;
    pwr_d = pwr_q;
    idx = '0;
    if (sel_s) begin
      // select high: idle, output released, everything powered down
      phase_d = IDLE;
      edge_d = '0;
      dout_d = '{o: 1'b0, oe: 1'b0};
      pwr_d = '{analog_pd: 1'b1, digital_pd: 1'b1};
    end else begin
      case (phase_q)
        IDLE: begin
          // a falling select starts; select low at reset also starts, as the synchronizer resets high
          if (sel_fall) begin
            phase_d = SAMPLE;
            edge_d = '0;
            sar_d = '0;
            valid_d = 1'b0;
            pwr_d = '{analog_pd: 1'b0, digital_pd: 1'b0};
          end
        end
        SAMPLE: begin
          dout_d.oe = 1'b0;
          if (sclk_fall) begin
            edge_d = edge_q + 1'b1;
            if (edge_q + 1'b1 == NULL_EDGE) begin
              phase_d = SHIFT;
              dout_d = '{o: 1'b0, oe: 1'b1};
            end
          end
        end
        SHIFT: begin
          if (sclk_fall) begin
            edge_d = edge_q + 1'b1;
            if (edge_d < REV_EDGE) begin
              // bit decided on this edge and driven at once, top first
              idx = CNT_W'(WIDTH - 1) - (edge_d - MSB_EDGE);
              sar_d[idx[3:0]] = comparator;
              dout_d.o = comparator;
            end else if (edge_d == REV_EDGE) begin
              // all bits decided: no comparator read here, or the top bit would be lost
              res_d = sar_q;
              valid_d = 1'b1;
              pwr_d.analog_pd = 1'b1;
              dout_d.o = sar_q[0];
            end else if (edge_d == DONE_EDGE) begin
              phase_d = DONE;
              dout_d = '{o: 1'b0, oe: 1'b0};
            end else begin
              idx = edge_d - REV_EDGE;
              dout_d.o = res_q[idx[3:0]];
            end
          end
        end
        DONE: begin
          // clocks ignored until select cycles; digital stays awake
          dout_d.oe = 1'b0;
          pwr_d = '{analog_pd: 1'b1, digital_pd: 1'b0};
        end
        default: phase_d = IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      phase_q <= IDLE;
      edge_q <= '0;
      sar_q <= RESULT_RST;
      res_q <= RESULT_RST;
      valid_q <= 1'b0;
      dout_q <= '{o: 1'b0, oe: 1'b0};
      pwr_q <= '{analog_pd: 1'b1, digital_pd: 1'b1};
    end else begin
      phase_q <= phase_d;
      edge_q <= edge_d;
      sar_q <= sar_d;
      res_q <= res_d;
      valid_q <= valid_d;
      dout_q <= dout_d;
      pwr_q <= pwr_d;
    end
  end

  assign dout = dout_q;
  assign power = pwr_q;
  assign result = res_q;
  assign result_valid = valid_q;

  sequence s_null_start;
    sclk_fall && !sel_s && phase_q == SAMPLE && edge_q == NULL_EDGE - 1'b1;
  endsequence

  a_null_bit_low: assert property (@(posedge clock) disable iff (!srst_n)
    s_null_start |=> dout_q.oe && !dout_q.o)
    else $error("null bit not driven low after fifth falling edge");
  a_sample_hiz: assert property (@(posedge clock) disable iff (!srst_n)
    phase_q == SAMPLE |-> !dout_q.oe)
    else $error("output driven during sampling");
  a_select_idle: assert property (@(posedge clock) disable iff (!srst_n)
    sel_s |=> phase_q == IDLE && edge_q == 0 && !dout_q.oe)
    else $error("select high did not idle the block");
  a_done_hiz: assert property (@(posedge clock) disable iff (!srst_n)
    phase_q == DONE |-> !dout_q.oe && power.analog_pd)
    else $error("output not released after reversed run");
  a_done_stays: assert property (@(posedge clock) disable iff (!srst_n)
    phase_q == DONE && !sel_s |=> phase_q == DONE)
    else $error("left done state without select cycling");
  a_edge_only_out: assert property (@(posedge clock) disable iff (!srst_n)
    !sclk_fall && !sel_s && phase_q == SHIFT |=> $stable(dout_q.o))
    else $error("output changed without a falling shift clock edge");
  a_start_fall: assert property (@(posedge clock) disable iff (!srst_n)
    phase_q == IDLE && !sel_fall |=> phase_q == IDLE)
    else $error("cycle started without select falling");
  a_rev_first: assert property (@(posedge clock) disable iff (!srst_n)
    sclk_fall && !sel_s && phase_q == SHIFT && edge_q == REV_EDGE
    |=> dout_q.o == res_q[1])
    else $error("reversed run out of order");
  a_pd_select: assert property (@(posedge clock) disable iff (!srst_n)
    sel_s |=> power.digital_pd && power.analog_pd)
    else $error("select high without full power down");

  sequence s_rev_start;
    sclk_fall && !sel_s && phase_q == SHIFT && edge_q == REV_EDGE - 1'b1;
  endsequence

  a_rev_capture: assert property (@(posedge clock) disable iff (!srst_n)
    s_rev_start |=> result_valid && res_q == $past(sar_q) && dout_q.o == res_q[0])
    else $error("result not captured whole at the start of the reversed run");
endmodule

// File: tb/host_model.sv
// host model: drives select and shift clock, samples the data line on rising edges
`timescale 1ns/100ps
module host_model
  import sar_readout_pkg::*;
(
  // clock
  input wire logic clock,
  // serial link
  input sar_readout_pkg::dout_pin_t dout,
  output logic serial_shift_clock,
  output logic select_n,
  output logic [5:0] falls
);
  import sar_readout_pkg::*;
  logic last_q = 1'b0;
  logic seen_oe [1:40];
  logic seen_v [1:40];
  // a released line shows the inverse of its last value, so a stale bit never passes
  always @(posedge clock) if (dout.oe) last_q <= dout.o;
  initial begin
    serial_shift_clock = 1'b1;
    select_n = 1'b1;
    falls = 6'h00;
  end
  task automatic frame(input logic low, input int n);
    @(posedge clock) select_n <= ~low;
    falls <= 6'h00;
    repeat (8) @(posedge clock);
    for (int k = 1; k <= n; k++) begin
      serial_shift_clock <= 1'b0;
      falls <= 6'(k);
      repeat (6) @(posedge clock);
      seen_oe[k] = dout.oe;
      seen_v[k] = dout.oe ? dout.o : ~last_q;
      serial_shift_clock <= 1'b1;
      repeat (6) @(posedge clock);
    end
  endtask
  // raising select ends or aborts the frame at any point
  task automatic release_sel();
    select_n <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the serial result readout
`timescale 1ns/100ps
module testbench;
  import sar_readout_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic comparator = 1'b0;
  logic serial_shift_clock;
  logic select_n;
  logic [5:0] falls;
  logic [15:0] code = 16'h0000;
  logic [15:0] result;
  logic result_valid;
  dout_pin_t dout;
  power_t power;
  int err_count = 0;
  int compares = 0;
  always #2 clock = ~clock;
  sar_serial_readout i_sar_serial_readout(.clock(clock), .rst_n(rst_n),
    .comparator(comparator), .serial_shift_clock(serial_shift_clock),
    .select_n(select_n), .dout(dout), .power(power), .result(result),
    .result_valid(result_valid));
  host_model i_host_model(.clock(clock), .dout(dout),
    .serial_shift_clock(serial_shift_clock), .select_n(select_n), .falls(falls));
  // analog side answers for the bit decided at the current fall
  always @(posedge clock) begin
    comparator <= (falls >= 6'h06 && falls <= 6'h15) ? code[6'h15 - falls] : 1'b0;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic judge(input logic live, input int n);
    logic e;
    for (int k = 1; k <= n; k++) begin
      chk("drive", 16'(live && k >= 5 && k <= 37), 16'(i_host_model.seen_oe[k]));
      e = k < 6 ? 1'b0 : k < 22 ? code[21 - k] : code[k - 22];
      if (live && k >= 5 && k <= 37) chk("bit", 16'(e), 16'(i_host_model.seen_v[k]));
    end
  endtask
  task automatic full_frame(input logic [15:0] value);
    code = value;
    i_host_model.frame(1'b1, 40);
    judge(1'b1, 40);
    chk("result", value, result);
    chk("valid", 16'h0001, 16'(result_valid));
    chk("power done", 16'h0002, 16'(power));
    i_host_model.release_sel();
    chk("power idle", 16'h0003, 16'(power));
  endtask
  task automatic abort_frame();
    code = 16'h5A3C;
    i_host_model.frame(1'b1, 19);
    judge(1'b1, 19);
    chk("valid abort", 16'h0000, 16'(result_valid));
    i_host_model.release_sel();
    chk("drive abort", 16'h0000, 16'(dout.oe));
    chk("power abort", 16'h0003, 16'(power));
    i_host_model.frame(1'b0, 40);
    judge(1'b0, 40);
    chk("power high", 16'h0003, 16'(power));
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    chk("reset power", 16'h0003, 16'(power));
    full_frame(16'hA5C3);
    full_frame(16'hFFFF);
    full_frame(16'h0000);
    abort_frame();
    full_frame(16'h8001);
    report_and_stop();
  end
  // whole run needs about 11 us
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
